// ### hw/scan_instruction_decoder.sv
// Instruction register and decoder of a boundary-scan test unit.
// Assumes a TAP state machine on the same clock (clk, sampled TCK domain)
// that supplies one-cycle state strobes and the serial instruction bit.
// The control-chain operation bits arrive already updated, on the same clock.
// No input crosses a clock domain, so none is synchronised here.
//
// Contract
// - Instruction is eight bits; bit seven keeps the opcode at even parity.
// - Opcodes 00 and 03 select boundary chain in test mode, capture pins.
// - Bypass opcodes and all unlisted opcodes select bypass, capture zero, normal mode.
// - Opcode 82 samples boundary chain while device stays in normal mode.
// - Opcode 06 selects bypass and floats all outputs; inputs and core keep working.
// - Opcode 87 selects bypass in test mode; stored cells drive core and pins.
// - Opcode 09 selects bypass in test mode; runs control-chain operation in Run-Test/Idle.
// - The control chain selects one of five run-test operations.
// - Opcodes 0a and 8b select boundary chain and hold it at capture.
// - Opcode 0c selects boundary chain in normal mode; cells capture their inverse.
// - Opcode 8d selects bypass in test mode; output cells toggle in Run-Test/Idle.
// - During toggle-outputs input cells hold and pins are not sampled.
// - Opcodes 8e and 0f select the control chain and hold it at capture.
// - Reset loads all ones, selecting bypass; Capture-IR loads 10000001.
// - A new instruction takes effect on the falling edge after Update-IR.
// - Run-test operation decodes from control bits two to zero.
`timescale 1ns/1ps
`default_nettype none
`include "scan_decoder_params.svh"

module scan_instruction_decoder (
   // Clock and asynchronous reset.
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   // TAP state strobes, all synchronous to clk.
   input  wire logic                           tap_reset,
   input  wire logic                           capture_ir,
   input  wire logic                           shift_ir,
   input  wire logic                           update_ir_fall,
   input  wire logic                           run_test_idle,
   // Serial instruction data and the updated control-chain operation bits.
   input  wire logic                           serial_in,
   input  wire logic [`RT_OP_WIDTH-1:0]        control_op,
   // Registered results.
   output logic                                serial_out,
   output logic                                parity_ok,
   output logic      [`IR_WIDTH-1:0]           instr_out,
   output scan_decoder_pkg::decode_t           ctrl,
   output logic                                run_active
);
   import scan_decoder_pkg::*;

   // Instruction shift stage, loaded at Capture-IR and shifted toward bit zero.
   logic [`IR_WIDTH-1:0] shift_r;
   logic [`IR_WIDTH-1:0] shift_nxt;

   // Updated instruction latch; the source of every decoded control but run_op, which also reads control_op.
   logic [`IR_WIDTH-1:0] latch_r;
   logic [`IR_WIDTH-1:0] latch_nxt;

   // Registered control bundle, so that every output leaves a flip-flop.
   decode_t              ctrl_r;
   decode_t              ctrl_nxt;

   // Parity verdict on the latched opcode.
   logic                 parity_r;
   logic                 parity_nxt;

   // Run-test activity flag.
   logic                 run_r;
   logic                 run_nxt;

   // Even parity over the whole opcode, parity bit included.
   // A parity error is only reported; the opcode is still decoded by value,
   // and odd-parity opcodes fall into bypass anyway.
   function automatic logic even_parity(input logic [`IR_WIDTH-1:0] op);
      even_parity = ~(^op);
   endfunction

   // Maps the low control bits onto a run-test operation.
   // The two exact codes are tested first, because they share low bits
   // with each other and differ only in the top bit.
   function automatic run_op_t run_decode(input logic [`RT_OP_WIDTH-1:0] code);
      run_op_t r;
      r = rt_signature16;

      // Exact codes first, then the families that ignore the top bit.
      if (code == `RT_SIG_PATTERN) begin
         r = rt_sig_pattern8;
      end else if (code == `RT_SIG_COUNT) begin
         r = rt_sig_count8;
      end else if ((code & `RT_LOW_MASK) == `RT_LOW_TOGGLE) begin
         r = rt_toggle;
      end else if ((code & `RT_LOW_MASK) == `RT_LOW_PATTERN) begin
         r = rt_pattern16;
      end
      run_decode = r;
   endfunction

   // Full decode of one latched opcode into the control bundle.
   // Every field starts at the bypass, normal-mode value, and each opcode
   // only overrides what it changes; unlisted opcodes keep those values.
   function automatic decode_t decode(input logic [`IR_WIDTH-1:0] op,
                                      input logic [`RT_OP_WIDTH-1:0] code);
      decode_t d;
      d = '0;

      // Defaults: bypass chain, pins sampled, nothing run.
      d.dr_sel              = dr_bypass;
      d.capture_src         = cap_none;
      d.bypass_capture_zero = 1'b1;
      d.input_sample_en     = 1'b1;
      d.run_op              = rt_none;

      case (op)
         // Boundary chain in test mode; cells capture pins and drive core and pins.
         `OP_BOUNDARY_EXT, `OP_BOUNDARY_INT: begin
            d.dr_sel           = dr_boundary;
            d.test_mode        = 1'b1;
            d.capture_src      = cap_pins;
            d.drive_from_cells = 1'b1;
         end

         // Sample: boundary chain, the device keeps its normal function.
         `OP_SAMPLE: begin
            d.dr_sel      = dr_boundary;
            d.capture_src = cap_pins;
         end

         // Outputs float; inputs and the core keep working.
         `OP_HIGH_IMPEDANCE: begin
            d.pins_high_z = 1'b1;
         end

         // Stored cell values drive the core inputs and the output pins.
         `OP_CLAMP_CELLS: begin
            d.test_mode        = 1'b1;
            d.drive_from_cells = 1'b1;
         end

         // Run test: the control chain picks the operation for Run-Test/Idle.
         `OP_RUN_TEST: begin
            d.test_mode        = 1'b1;
            d.drive_from_cells = 1'b1;
            d.run_op           = run_decode(code);
         end

         // Read in normal mode: the chain keeps its contents at capture.
         `OP_READ_NORMAL: begin
            d.dr_sel      = dr_boundary;
            d.capture_src = cap_hold;
         end

         // Read in test mode: as above, with the cells driving.
         `OP_READ_TEST: begin
            d.dr_sel           = dr_boundary;
            d.test_mode        = 1'b1;
            d.capture_src      = cap_hold;
            d.drive_from_cells = 1'b1;
         end

         // Self check: every cell captures the inverse of its value.
         `OP_CELL_CHECK: begin
            d.dr_sel      = dr_boundary;
            d.capture_src = cap_invert;
         end

         // Toggle outputs: input cells hold and the pins are not sampled.
         `OP_TOGGLE_OUTPUTS: begin
            d.test_mode        = 1'b1;
            d.drive_from_cells = 1'b1;
            d.output_toggle_en = 1'b1;
            d.input_sample_en  = 1'b0;
            d.run_op           = rt_toggle;
         end

         // Control chain scan in normal mode.
         `OP_CTRL_SCAN_NORM: begin
            d.dr_sel      = dr_control;
            d.capture_src = cap_hold;
         end

         // Control chain scan in test mode.
         `OP_CTRL_SCAN_TEST: begin
            d.dr_sel           = dr_control;
            d.test_mode        = 1'b1;
            d.capture_src      = cap_hold;
            d.drive_from_cells = 1'b1;
         end

         // Every other opcode behaves as bypass.
         default: begin
            d.dr_sel = dr_bypass;
         end
      endcase

      // Whenever bypass is selected it captures zero at Capture-DR.
      d.bypass_capture_zero = (d.dr_sel == dr_bypass);
      decode = d;
   endfunction

   // Shift stage: capture fixed pattern, shift toward the LSB, reset to ones.
   // Strobe priority is reset, then capture, then shift, so a stray overlap
   // of strobes always resolves toward the safe bypass state.
   always_comb begin
      shift_nxt = shift_r;
      if (tap_reset) begin
         shift_nxt = `IR_RESET_VALUE;
      end else if (capture_ir) begin
         shift_nxt = `IR_CAPTURE_VALUE;
      end else if (shift_ir) begin
         shift_nxt = {serial_in, shift_r[`IR_WIDTH-1:1]};
      end
   end

   // Latch stage: changes only on Test-Logic-Reset or the update strobe, which marks the falling
   // edge after Update-IR, so a half-scanned opcode never reaches the decode.
   // Parity is judged on the same value that is latched.
   always_comb begin
      latch_nxt  = latch_r;
      parity_nxt = parity_r;
      if (tap_reset) begin
         latch_nxt  = `IR_RESET_VALUE;
         parity_nxt = even_parity(`IR_RESET_VALUE);
      end else if (update_ir_fall) begin
         latch_nxt  = shift_r;
         parity_nxt = even_parity(shift_r);
      end
   end

   // Decode of the next latch value, so controls change in step with the latch.
   // Reading the shift stages here would let half-scanned opcodes reach the pins.
   always_comb begin
      ctrl_nxt = decode(latch_nxt, control_op);
   end

   // Run-test activity: only in Run-Test/Idle and only for an opcode that runs.
   // Test-Logic-Reset stops it at once.
   always_comb begin
      run_nxt = run_test_idle && (ctrl_nxt.run_op != rt_none) && !tap_reset;
   end

   // Instruction shift stage register.
   // Reset loads all ones, as Test-Logic-Reset does.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= `IR_RESET_VALUE;
      end else begin
         shift_r <= shift_nxt;
      end
   end

   // Instruction latch and parity flag.
   // The reset value selects bypass and has even parity.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_r  <= `IR_RESET_VALUE;
         parity_r <= `IR_RESET_PARITY;
      end else begin
         latch_r  <= latch_nxt;
         parity_r <= parity_nxt;
      end
   end

   // Control bundle register.
   // Its reset value is the decode of bypass in normal mode.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r.dr_sel              <= dr_bypass;
         ctrl_r.test_mode           <= 1'b0;
         ctrl_r.capture_src         <= cap_none;
         ctrl_r.bypass_capture_zero <= 1'b1;
         ctrl_r.pins_high_z         <= 1'b0;
         ctrl_r.drive_from_cells    <= 1'b0;
         ctrl_r.input_sample_en     <= 1'b1;
         ctrl_r.output_toggle_en    <= 1'b0;
         ctrl_r.run_op              <= rt_none;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Run-test activity register.
   // Cleared by reset so no operation runs before an instruction is loaded.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_r <= 1'b0;
      end else begin
         run_r <= run_nxt;
      end
   end

   // Outputs come straight from flip-flops.
   // No logic stands between the registers and the ports.
   always_comb begin
      serial_out = shift_r[0];
      parity_ok  = parity_r;
      instr_out  = latch_r;
      ctrl       = ctrl_r;
      run_active = run_r;
   end

endmodule
`default_nettype wire

// ### hw/scan_decoder_params.svh
// Constants for the scan instruction decoder: opcodes, widths, reset values.
// Assumes inclusion by bare name ahead of the package and the decoder module.
`ifndef SCAN_DECODER_PARAMS_SVH
`define SCAN_DECODER_PARAMS_SVH

`define IR_WIDTH           8
`define IR_PARITY_BIT      7
`define IR_RESET_VALUE     8'hff
`define IR_CAPTURE_VALUE   8'h81
`define IR_RESET_PARITY    1'b1
`define OP_BOUNDARY_EXT    8'h00
`define OP_BOUNDARY_INT    8'h03
`define OP_SAMPLE          8'h82
`define OP_HIGH_IMPEDANCE  8'h06
`define OP_CLAMP_CELLS     8'h87
`define OP_RUN_TEST        8'h09
`define OP_READ_NORMAL     8'h0a
`define OP_READ_TEST       8'h8b
`define OP_CELL_CHECK      8'h0c
`define OP_TOGGLE_OUTPUTS  8'h8d
`define OP_CTRL_SCAN_NORM  8'h8e
`define OP_CTRL_SCAN_TEST  8'h0f
`define RT_OP_WIDTH        3
`define RT_LOW_MASK        3'h3
`define RT_LOW_TOGGLE      3'h0
`define RT_LOW_PATTERN     3'h1
`define RT_LOW_SIGNATURE   3'h2
`define RT_SIG_PATTERN     3'h3
`define RT_SIG_COUNT       3'h7

`endif

// ### hw/scan_decoder_pkg.sv
// Types shared by the scan instruction decoder and its surroundings.
// Assumes the parameter header is found on the include path.
`include "scan_decoder_params.svh"

package scan_decoder_pkg;

   // Data register placed between the serial input and output.
   typedef enum logic [1:0] {
      dr_bypass,
      dr_boundary,
      dr_control
   } dr_select_t;

   // What the boundary cells load at Capture-DR.
   typedef enum logic [1:0] {
      cap_pins,
      cap_hold,
      cap_invert,
      cap_none
   } capture_src_t;

   // Operation run in Run-Test/Idle.
   typedef enum logic [2:0] {
      rt_none,
      rt_toggle,
      rt_pattern16,
      rt_signature16,
      rt_sig_pattern8,
      rt_sig_count8
   } run_op_t;

   // Decoded controls handed to the scan chains and pin logic.
   typedef struct packed {
      dr_select_t   dr_sel;
      logic         test_mode;
      capture_src_t capture_src;
      logic         bypass_capture_zero;
      logic         pins_high_z;
      logic         drive_from_cells;
      logic         input_sample_en;
      logic         output_toggle_en;
      run_op_t      run_op;
   } decode_t;

endpackage

// ### tb/decoder_monitor.sv
// Checker for the scan instruction decoder; sees only the decoder's ports.
// Assumes one clock domain, clk, with the asynchronous active-low rst_n.
`timescale 1ns/1ps
`default_nettype none
module decoder_monitor
   import scan_decoder_pkg::*;
(
   input wire logic      clk,
   input wire logic      rst_n,
   input wire logic      tap_reset,
   input wire logic      capture_ir,
   input wire logic      shift_ir,
   input wire logic      update_ir_fall,
   input wire logic      run_test_idle,
   input wire logic      serial_in,
   input wire logic      serial_out,
   input wire logic      parity_ok,
   input wire logic [7:0] instr_out,
   input wire decode_t   ctrl,
   input wire logic      run_active
);
   logic [7:0] sh_r;
   logic [7:0] sh_nxt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Shadow copy of the instruction shift stages, used to predict loads.
   always_comb begin
      sh_nxt = sh_r;
      if (tap_reset) sh_nxt = 8'hff;
      else if (capture_ir) sh_nxt = 8'h81;
      else if (shift_ir) sh_nxt = {serial_in, sh_r[7:1]};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sh_r <= 8'hff;
      else sh_r <= sh_nxt;
   end
   sequence shift_step; shift_ir && !capture_ir && !tap_reset; endsequence
   sequence idle_step; !update_ir_fall && !tap_reset; endsequence
   instr_hold_a: assert property (idle_step |=> $stable(instr_out)) else $error("instruction changed without update");
   instr_load_a: assert property (update_ir_fall && !tap_reset |=> instr_out == $past(sh_r)) else $error("wrong instruction loaded");
   reset_ones_a: assert property (tap_reset |=> instr_out == 8'hff && ctrl.dr_sel == dr_bypass) else $error("reset value wrong");
   capture_value_a: assert property (capture_ir && !tap_reset |=> serial_out == 1'b1) else $error("capture pattern wrong");
   shift_order_a: assert property (shift_step |=> serial_out == $past(sh_r[1])) else $error("shift order wrong");
   parity_flag_a: assert property (parity_ok == ~(^instr_out)) else $error("parity flag wrong");
   ctrl_select_a: assert property (ctrl.dr_sel == dr_control |-> instr_out inside {8'h8e, 8'h0f}) else $error("control chain misselected");
   invert_cap_a: assert property (ctrl.capture_src == cap_invert |-> instr_out == 8'h0c && !ctrl.test_mode) else $error("invert capture misdecoded");
   high_z_a: assert property (ctrl.pins_high_z |-> instr_out == 8'h06 && ctrl.dr_sel == dr_bypass) else $error("high impedance misdecoded");
   run_start_a: assert property ($rose(run_active) |-> $past(run_test_idle)) else $error("run started outside idle");
endmodule
bind scan_instruction_decoder decoder_monitor u_mon (.clk(clk), .rst_n(rst_n), .tap_reset(tap_reset),
   .capture_ir(capture_ir), .shift_ir(shift_ir), .update_ir_fall(update_ir_fall), .run_test_idle(run_test_idle),
   .serial_in(serial_in), .serial_out(serial_out), .parity_ok(parity_ok), .instr_out(instr_out), .ctrl(ctrl),
   .run_active(run_active));
`default_nettype wire

// ### tb/tap_ir_driver.sv
// Behavioural test-bus controller that runs one instruction scan per request.
// Assumes go is held for one clock; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module tap_ir_driver (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [7:0] opcode,
   output var logic        capture_ir,
   output var logic        shift_ir,
   output var logic        update_ir_fall,
   output var logic        serial_in,
   output var logic        done
);
   integer i;
   // Capture, eight shifts lowest bit first, then the update strobe.
   initial begin
      {capture_ir, shift_ir, update_ir_fall, serial_in, done} = 5'h0;
      forever begin
         @(posedge clk);
         if (go) begin
            #1 capture_ir = 1'b1;
            @(posedge clk) #1 capture_ir = 1'b0;
            shift_ir = 1'b1;
            for (i = 0; i < 8; i++) begin
               serial_in = opcode[i];
               @(posedge clk) #1;
            end
            shift_ir = 1'b0;
            serial_in = ~serial_in; // Released line shows the inverse.
            update_ir_fall = 1'b1;
            @(posedge clk) #1 update_ir_fall = 1'b0;
            done = 1'b1;
            @(posedge clk) #1 done = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/scan_instruction_decoder_tb.sv
// Self-checking bench: opcode table, run-test decoding, resets.
// Assumes the decoder, its package and the scan driver are compiled first.
`timescale 1ns/1ps
`default_nettype none
module scan_instruction_decoder_tb;
   import scan_decoder_pkg::*;
   typedef struct {logic [7:0] op; dr_select_t dr; logic tm; capture_src_t cap;} row_t;
   logic clk = 0, rst_n = 0, tap_reset = 0, rti = 0, go = 0, cap, shf, upd, sin, done, sout, pok, ract;
   logic [2:0] cop = 3'h0;
   logic [7:0] op = 8'h00, iout;
   decode_t    ctrl;
   int         fail_count = 0, check_count = 0, k;
   row_t rows[18] = '{'{8'h00,dr_boundary,1,cap_pins}, '{8'h03,dr_boundary,1,cap_pins}, '{8'h81,dr_bypass,0,cap_none},
      '{8'h84,dr_bypass,0,cap_none}, '{8'h05,dr_bypass,0,cap_none}, '{8'h88,dr_bypass,0,cap_none},
      '{8'h82,dr_boundary,0,cap_pins}, '{8'h06,dr_bypass,0,cap_none}, '{8'h87,dr_bypass,1,cap_none},
      '{8'h09,dr_bypass,1,cap_none}, '{8'h0a,dr_boundary,0,cap_hold}, '{8'h8b,dr_boundary,1,cap_hold},
      '{8'h0c,dr_boundary,0,cap_invert}, '{8'h8d,dr_bypass,1,cap_none}, '{8'h8e,dr_control,0,cap_hold},
      '{8'h0f,dr_control,1,cap_hold}, '{8'h01,dr_bypass,0,cap_none}, '{8'hff,dr_bypass,0,cap_none}};
   run_op_t rexp[8] = '{rt_toggle, rt_pattern16, rt_signature16, rt_sig_pattern8,
      rt_toggle, rt_pattern16, rt_signature16, rt_sig_count8};
   always #20 clk = ~clk;
   scan_instruction_decoder dut (.clk(clk), .rst_n(rst_n), .tap_reset(tap_reset), .capture_ir(cap), .shift_ir(shf),
      .update_ir_fall(upd), .run_test_idle(rti), .serial_in(sin), .control_op(cop), .serial_out(sout),
      .parity_ok(pok), .instr_out(iout), .ctrl(ctrl), .run_active(ract));
   tap_ir_driver drv (.clk(clk), .go(go), .opcode(op), .capture_ir(cap), .shift_ir(shf), .update_ir_fall(upd),
      .serial_in(sin), .done(done));
   // Compares one value and counts the outcome.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Scans one opcode in and waits, bounded, for the driver to finish.
   task automatic load(input logic [7:0] o);
      int n;
      op = o;
      go = 1'b1;
      @(posedge clk) #1 go = 1'b0;
      for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge clk);
      #1;
      if (n == 40) begin
         fail_count++;
         $display("CHECK FAILED t=%0t scan never completed", $time);
         tally_and_finish();
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      check(iout, 8'hff);
      check(8'(ctrl.dr_sel), 8'(dr_bypass));
      $display("test reset done");
      foreach (rows[k]) begin
         load(rows[k].op);
         check(iout, rows[k].op);
         check(8'(ctrl.dr_sel), 8'(rows[k].dr));
         check(8'(ctrl.test_mode), 8'(rows[k].tm));
         check(8'(ctrl.capture_src), 8'(rows[k].cap));
         check(8'(pok), 8'(~^rows[k].op));
         check(8'(ctrl.pins_high_z), 8'(rows[k].op == 8'h06));
         check(8'(ctrl.bypass_capture_zero), 8'(rows[k].dr == dr_bypass));
         check(8'(ctrl.drive_from_cells), 8'(rows[k].tm));
         check(8'(ctrl.output_toggle_en), 8'(rows[k].op == 8'h8d));
         check(8'(ctrl.input_sample_en), 8'(rows[k].op != 8'h8d));
      end
      $display("test opcode table done");
      load(8'h8d);
      check(8'(ctrl.run_op), 8'(rt_toggle));
      check(8'(ctrl.input_sample_en), 8'h0);
      cop = 3'h7; // Control chain is set before the run-test opcode.
      load(8'h09);
      for (k = 0; k < 8; k++) begin
         cop = 3'(k);
         repeat (2) @(posedge clk);
         #1 check(8'(ctrl.run_op), 8'(rexp[k]));
      end
      rti = 1'b1;
      repeat (2) @(posedge clk);
      #1 check(8'(ract), 8'h1);
      rti = 1'b0;
      $display("test run operations done");
      load(8'h0f);
      tap_reset = 1'b1;
      @(posedge clk) #1 tap_reset = 1'b0;
      check(iout, 8'hff);
      check(8'(ctrl.dr_sel), 8'(dr_bypass));
      load(8'h00);
      rst_n = 1'b0;
      #5 check(iout, 8'hff);
      check(8'(ract), 8'h0);
      @(posedge clk) #1 rst_n = 1'b1;
      check(iout, 8'hff);
      load(8'h82);
      check(iout, 8'h82);
      check(8'(ctrl.dr_sel), 8'(dr_boundary));
      check(8'(ctrl.test_mode), 8'h0);
      $display("test mid-run resets done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
